// [pkg/gpio_port_pkg.sv]
// constants, types and register map of the configurable io port set
package gpio_port_pkg;

	localparam int NUM_PORTS = 4;
	localparam int PORT_WIDTH = 8;
	localparam int NUM_PINS = 26;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// implemented pins per port; port 3 has two
	localparam logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] PORT_MASK = {8'h03, 8'hFF, 8'hFF, 8'hFF};

	// register map, byte addresses; port n block sits at n * PORT_STRIDE
	localparam logic [ADDR_W-1:0] PORT_STRIDE = 8'h10;
	localparam logic [ADDR_W-1:0] OFF_LATCH = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_CFG_A = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_CFG_B = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_PINS = 8'h0C;
	localparam logic [ADDR_W-1:0] OFF_PORT0_DIG_DIS = 8'h40;
	localparam logic [ADDR_W-1:0] OFF_USER_CFG1 = 8'h44;
	localparam logic [ADDR_W-1:0] PORT_SPAN = 8'h40;

	// reset values
	localparam logic [PORT_WIDTH-1:0] LATCH_RST = 8'hFF;
	localparam logic [PORT_WIDTH-1:0] CFG_A_RST = 8'hFF;
	localparam logic [PORT_WIDTH-1:0] CFG_B_RST = 8'h00;
	localparam logic [PORT_WIDTH-1:0] DIG_DIS_RST = 8'h00;
	localparam logic [PORT_WIDTH-1:0] DIG_DIS_MASK = 8'h3E;
	localparam logic [PORT_WIDTH-1:0] USER_CFG1_RST = 8'h00;
	localparam int RESET_PIN_EN_BIT = 6;

	// flat pin indices (port * 8 + bit)
	localparam int PIN_RESET = 13;
	localparam int PIN_SERIAL_CLK = 10;
	localparam int PIN_SERIAL_DATA = 11;

	// glitch suppression, least time, rounded up to whole cycles
	localparam int CLK_PERIOD_NS = 8;
	localparam int GLITCH_NS = 16;
	localparam int GLITCH_CYC_RAW = (GLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int GLITCH_CYC = (GLITCH_CYC_RAW < 1) ? 1 : GLITCH_CYC_RAW;

	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_DECERR = 2'b11;

	// {cfg_a bit, cfg_b bit}
	typedef enum logic [1:0] {
		DRV_QUASI = 2'b00,
		DRV_PUSH_PULL = 2'b01,
		DRV_INPUT_ONLY = 2'b10,
		DRV_OPEN_DRAIN = 2'b11
	} drive_mode_t;

	typedef struct packed {
		logic out;
		logic oe_n;
		logic weak_pu;
	} pad_drive_t;

endpackage

// [rtl/configurable_io_port_set.sv]
// four gpio ports with per-pin drive type and an axi4-lite register slave
//
// Register access over AXI4-Lite and the register offsets were decided locally.
`timescale 1ns/1ps

// Overview of operation
// - ports 0-2 eight pins, port 3 two
// - each pin picks one of four drives
// - two config registers per port select drive
// - port 1 bit 5 always input-only
// - port 1 bits 2,3 input-only or open-drain
// - quasi: weak high, strong low, readable
// - open-drain: pull low only when latch zero
// - input-only: drivers off, input still active
// - push-pull: strong high on one, low on zero
// - every input synchronised and glitch filtered
// - port 0 bits 1-5 disable digital input
// - all pins input-only after reset
// - reset-pin enable makes bit 5 reset input
module configurable_io_port_set
	import gpio_port_pkg::*;
#(
	parameter int GLITCH_CYCLES = GLITCH_CYC,
	parameter logic [PORT_WIDTH-1:0] USER_CFG1_INIT = USER_CFG1_RST
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [NUM_PINS-1:0] pin_in,
	output pad_drive_t [NUM_PINS-1:0] pad,
	output logic pin_reset_req
);

	localparam int CNT_W = $clog2(GLITCH_CYCLES + 1);

	// ports kept 8 wide, unimplemented bits masked to zero
	logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] latch_r;
	logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] cfg_a_r;
	logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] cfg_b_r;
	logic [PORT_WIDTH-1:0] port0_digital_input_disable_r;
	logic [PORT_WIDTH-1:0] user_config_byte_one_r;
	logic [NUM_PINS-1:0] pin_filt;
	logic [NUM_PORTS-1:0][PORT_WIDTH-1:0] pins_view;
	pad_drive_t [NUM_PINS-1:0] pad_nxt;
	logic reset_pin_function_enable;

	assign reset_pin_function_enable = user_config_byte_one_r[RESET_PIN_EN_BIT];

	////////////////////////////////////////////////////////////////////////////////
	// pin input path

	genvar gi;
	generate
		for (gi = 0; gi < NUM_PINS; gi++) begin : g_in
			logic meta_r;
			logic sync_r;
			logic filt_r;
			logic [CNT_W-1:0] cnt_r;

			always_ff @(posedge clk_sys) begin
				if (rst) begin
					meta_r <= 1'b1;
					sync_r <= 1'b1;
				end else begin
					meta_r <= pin_in[gi];
					sync_r <= meta_r;
				end
			end

			// glitch suppression: change needs stable run
			always_ff @(posedge clk_sys) begin
				if (rst) begin
					filt_r <= 1'b1;
					cnt_r <= '0;
				end else if (sync_r == filt_r) begin
					cnt_r <= '0;
				end else if (cnt_r == CNT_W'(GLITCH_CYCLES - 1)) begin
					filt_r <= sync_r;
					cnt_r <= '0;
				end else begin
					cnt_r <= cnt_r + 1'b1;
				end
			end

			assign pin_filt[gi] = filt_r;
		end
	endgenerate

	// disabled port 0 inputs read as zero
	always_comb begin
		pins_view = '0;
		for (int i = 0; i < NUM_PINS; i++) begin
			pins_view[i / PORT_WIDTH][i % PORT_WIDTH] = pin_filt[i];
		end
		pins_view[0] = pins_view[0] & ~port0_digital_input_disable_r;
	end

	////////////////////////////////////////////////////////////////////////////////
	// pad drive

	always_comb begin
		drive_mode_t mode;
		logic lat;
		mode = DRV_INPUT_ONLY;
		lat = 1'b0;
		for (int i = 0; i < NUM_PINS; i++) begin
			lat = latch_r[i / PORT_WIDTH][i % PORT_WIDTH];
			// per-pin mode from the cfg pair
			// cfg_a bit high, cfg_b bit low
			mode = drive_mode_t'({cfg_a_r[i / PORT_WIDTH][i % PORT_WIDTH],
				cfg_b_r[i / PORT_WIDTH][i % PORT_WIDTH]});
			if (i == PIN_RESET) begin
				mode = DRV_INPUT_ONLY;
			end
			// serial pins fall back to input-only
			if ((i == PIN_SERIAL_CLK || i == PIN_SERIAL_DATA) &&
				mode != DRV_OPEN_DRAIN) begin
				mode = DRV_INPUT_ONLY;
			end
			pad_nxt[i] = '{out: 1'b0, oe_n: 1'b1, weak_pu: 1'b0};
			case (mode)
				// strong low, weak high so others can pull
				DRV_QUASI: begin
					pad_nxt[i].oe_n = lat;
					pad_nxt[i].weak_pu = lat;
				end
				DRV_PUSH_PULL: begin
					pad_nxt[i].out = lat;
					pad_nxt[i].oe_n = 1'b0;
				end
				DRV_OPEN_DRAIN: begin
					pad_nxt[i].oe_n = lat;
				end
				DRV_INPUT_ONLY: begin
					pad_nxt[i].oe_n = 1'b1;
				end
				default: begin
					pad_nxt[i].oe_n = 1'b1;
				end
			endcase
			// reset input function keeps its internal pull-up
			if (i == PIN_RESET && reset_pin_function_enable) begin
				pad_nxt[i].weak_pu = 1'b1;
			end
		end
	end

	// reset cfg gives input-only so pads float
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pad <= {NUM_PINS{pad_drive_t'(3'b010)}};
		end else begin
			pad <= pad_nxt;
		end
	end

	// active-low pin level requests reset when enabled
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			pin_reset_req <= 1'b0;
		end else begin
			pin_reset_req <= reset_pin_function_enable & ~pin_filt[PIN_RESET];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// axi4-lite write channel

	logic aw_full_r;
	logic w_full_r;
	logic [ADDR_W-1:0] aw_addr_r;
	logic [DATA_W-1:0] w_data_r;
	logic [3:0] w_strb_r;
	logic do_write;
	logic aw_full_nxt;
	logic w_full_nxt;
	logic bvalid_nxt;
	logic wr_hit;
	logic [ADDR_W-1:0] wr_port;
	logic [ADDR_W-1:0] wr_off;

	// address and data accepted in either order, answer after both
	assign do_write = aw_full_r & w_full_r & ~s_axi_bvalid;
	assign aw_full_nxt = (aw_full_r | (s_axi_awvalid & s_axi_awready)) & ~do_write;
	assign w_full_nxt = (w_full_r | (s_axi_wvalid & s_axi_wready)) & ~do_write;
	assign bvalid_nxt = do_write | (s_axi_bvalid & ~s_axi_bready);
	assign wr_port = aw_addr_r / PORT_STRIDE;
	assign wr_off = aw_addr_r % PORT_STRIDE;
	assign wr_hit = (aw_addr_r < PORT_SPAN && wr_off[1:0] == 2'b00) ||
		aw_addr_r == OFF_PORT0_DIG_DIS || aw_addr_r == OFF_USER_CFG1;

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			aw_full_r <= 1'b0;
			w_full_r <= 1'b0;
			aw_addr_r <= '0;
			w_data_r <= '0;
			w_strb_r <= '0;
		end else begin
			aw_full_r <= aw_full_nxt;
			w_full_r <= w_full_nxt;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_addr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_data_r <= s_axi_wdata;
				w_strb_r <= s_axi_wstrb;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else begin
			s_axi_awready <= ~aw_full_nxt & ~bvalid_nxt;
			s_axi_wready <= ~w_full_nxt & ~bvalid_nxt;
			s_axi_bvalid <= bvalid_nxt;
			if (do_write) begin
				s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_DECERR;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			latch_r <= {NUM_PORTS{LATCH_RST}} & PORT_MASK;
			cfg_a_r <= {NUM_PORTS{CFG_A_RST}} & PORT_MASK;
			cfg_b_r <= {NUM_PORTS{CFG_B_RST}} & PORT_MASK;
		end else if (do_write && w_strb_r[0] && aw_addr_r < PORT_SPAN) begin
			case (wr_off)
				OFF_LATCH: latch_r[wr_port[1:0]] <= w_data_r[7:0] & PORT_MASK[wr_port[1:0]];
				OFF_CFG_A: cfg_a_r[wr_port[1:0]] <= w_data_r[7:0] & PORT_MASK[wr_port[1:0]];
				OFF_CFG_B: cfg_b_r[wr_port[1:0]] <= w_data_r[7:0] & PORT_MASK[wr_port[1:0]];
				default: begin
				end
			endcase
		end
	end

	// bits 1..5 only, cleared by every reset
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			port0_digital_input_disable_r <= DIG_DIS_RST;
		end else if (do_write && w_strb_r[0] && aw_addr_r == OFF_PORT0_DIG_DIS) begin
			port0_digital_input_disable_r <= w_data_r[7:0] & DIG_DIS_MASK;
		end
	end

	// user config byte holds the reset-pin enable
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			user_config_byte_one_r <= USER_CFG1_INIT;
		end else if (do_write && w_strb_r[0] && aw_addr_r == OFF_USER_CFG1) begin
			user_config_byte_one_r <= w_data_r[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// axi4-lite read channel

	logic ar_take;
	logic [PORT_WIDTH-1:0] rd_byte;
	logic rd_hit;
	logic [ADDR_W-1:0] rd_port;
	logic [ADDR_W-1:0] rd_off;

	assign ar_take = s_axi_arvalid & s_axi_arready;
	assign rd_port = s_axi_araddr / PORT_STRIDE;
	assign rd_off = s_axi_araddr % PORT_STRIDE;

	always_comb begin
		rd_byte = '0;
		rd_hit = 1'b1;
		if (s_axi_araddr < PORT_SPAN) begin
			case (rd_off)
				OFF_LATCH: rd_byte = latch_r[rd_port[1:0]];
				OFF_CFG_A: rd_byte = cfg_a_r[rd_port[1:0]];
				OFF_CFG_B: rd_byte = cfg_b_r[rd_port[1:0]];
				OFF_PINS: rd_byte = pins_view[rd_port[1:0]];
				default: rd_hit = 1'b0;
			endcase
		end else if (s_axi_araddr == OFF_PORT0_DIG_DIS) begin
			rd_byte = port0_digital_input_disable_r;
		end else if (s_axi_araddr == OFF_USER_CFG1) begin
			rd_byte = user_config_byte_one_r;
		end else begin
			rd_hit = 1'b0;
		end
	end

	// one read at a time; arready drops while the answer waits
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			if (ar_take) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {{(DATA_W - PORT_WIDTH){1'b0}}, rd_byte};
				s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_DECERR;
				s_axi_arready <= 1'b0;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
				s_axi_arready <= 1'b1;
			end else begin
				s_axi_arready <= ~s_axi_rvalid;
			end
		end
	end

endmodule

// [testbench/io_port_asserts.sv]
// concurrent checks on the io port set ports
`timescale 1ns/1ps
module io_port_asserts
	import gpio_port_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [DATA_W-1:0] s_axi_rdata,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input pad_drive_t [NUM_PINS-1:0] pad
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////
	sequence s_wr_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_rd_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	property p_wr_answer; s_wr_taken |-> ##[1:2] s_axi_bvalid; endproperty
	property p_b_hold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	property p_rd_answer; s_rd_taken |=> s_axi_rvalid; endproperty
	property p_r_hold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
	endproperty
	property p_aw_busy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
	property p_rdata_upper; s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0; endproperty
	property p_reset_pin; pad[PIN_RESET].oe_n; endproperty
	property p_serial_od;
		(!pad[PIN_SERIAL_CLK].oe_n |-> !pad[PIN_SERIAL_CLK].out) and
		(!pad[PIN_SERIAL_DATA].oe_n |-> !pad[PIN_SERIAL_DATA].out);
	endproperty
	// pin 0 may not drive or pull up straight out of reset, and no answer may be pending
	property p_reset_float;
		$past(rst) |-> !s_axi_bvalid && !s_axi_rvalid && pad[0].oe_n && !pad[0].weak_pu;
	endproperty
	a_wr_answer: assert property (p_wr_answer) else $error("write answer late");
	a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
	a_rd_answer: assert property (p_rd_answer) else $error("read answer late");
	a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
	a_aw_busy: assert property (p_aw_busy) else $error("write taken while busy");
	a_rdata_upper: assert property (p_rdata_upper) else $error("rdata upper set");
	a_reset_pin: assert property (p_reset_pin) else $error("reset pin driven");
	a_serial_od: assert property (p_serial_od) else $error("serial pin high");
	a_reset_float: assert property (p_reset_float) else $error("pad after reset");
endmodule

// [testbench/pin_world.sv]
// external circuitry on the port pins
`timescale 1ns/1ps
module pin_world
	import gpio_port_pkg::*;
(
	input pad_drive_t [NUM_PINS-1:0] pad,
	input wire logic [NUM_PINS-1:0] drv_en,
	input wire logic [NUM_PINS-1:0] drv_val,
	output logic [NUM_PINS-1:0] pin_in
);
	// strong drive wins, outside driver beats weak pull-up, board pull-up else
	always_comb begin
		for (int i = 0; i < NUM_PINS; i++) begin
			if (!pad[i].oe_n) pin_in[i] = pad[i].out;
			else if (drv_en[i]) pin_in[i] = drv_val[i];
			else pin_in[i] = 1'b1;
		end
	end
endmodule

// [testbench/configurable_io_port_set_tb.sv]
// self-checking bench for the io port set
`timescale 1ns/1ps
module configurable_io_port_set_tb;
	import gpio_port_pkg::*;
	logic clk_sys = 0, rst = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
	logic [7:0] awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic awready, wready, bvalid, arready, rvalid, rst_req;
	logic [1:0] bresp, rresp, resp;
	logic [3:0] wstrb = 4'hF;
	logic [NUM_PINS-1:0] pin_in, drv_en = '0, drv_val = '0;
	pad_drive_t [NUM_PINS-1:0] pad;
	logic [7:0] ca [4], cb [4], la [4], m;
	logic [31:0] v;
	int seed = 68690, miscompares = 0, n_tests = 0, cyc = 0;
	configurable_io_port_set #(.GLITCH_CYCLES(2)) DUT (.clk_sys(clk_sys), .rst(rst),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .pin_in(pin_in), .pad(pad), .pin_reset_req(rst_req));
	pin_world ext (.pad(pad), .drv_en(drv_en), .drv_val(drv_val), .pin_in(pin_in));
	initial forever #4 clk_sys = ~clk_sys;
	////////////////////////////////////////////////////////////////
	task automatic stop_test();
		if (miscompares == 0 && n_tests > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("MISMATCH %s exp %h seen %h", name, exp, seen);
		end
	endtask
	// each channel released at its own handshake; random stall before bready
	task automatic wr(input int a, input logic [7:0] d);
		logic aw_done;
		logic w_done;
		int stall;
		aw_done = 0;
		w_done = 0;
		stall = $unsigned($random(seed)) % 3;
		awaddr <= 8'(a);
		wdata <= {24'h0, d};
		awvalid <= 1;
		wvalid <= 1;
		while (!(aw_done && w_done)) begin
			@(posedge clk_sys);
			if (!aw_done && awready) begin
				aw_done = 1;
				awvalid <= 0;
			end
			if (!w_done && wready) begin
				w_done = 1;
				wvalid <= 0;
			end
		end
		repeat (stall) @(posedge clk_sys);
		bready <= 1;
		do @(posedge clk_sys); while (!bvalid);
		resp = bresp;
		bready <= 0;
	endtask
	// random stall before rready so the slave must hold its answer
	task automatic rd(input int a);
		int stall;
		stall = $unsigned($random(seed)) % 3;
		araddr <= 8'(a);
		arvalid <= 1;
		do @(posedge clk_sys); while (!arready);
		arvalid <= 0;
		repeat (stall) @(posedge clk_sys);
		rready <= 1;
		do @(posedge clk_sys); while (!rvalid);
		v = rdata;
		resp = rresp;
		rready <= 0;
	endtask
	// drive code {oe_n, weak pull-up when released, else driven level}
	function automatic logic [1:0] exp_pad(int i, logic l, drive_mode_t d);
		if (i == PIN_RESET) d = DRV_INPUT_ONLY;
		if ((i == PIN_SERIAL_CLK || i == PIN_SERIAL_DATA) && d != DRV_OPEN_DRAIN)
			d = DRV_INPUT_ONLY;
		case (d)
			DRV_QUASI: return l ? 2'b11 : 2'b00;
			DRV_PUSH_PULL: return {1'b0, l};
			DRV_OPEN_DRAIN: return l ? 2'b10 : 2'b00;
			default: return 2'b10;
		endcase
	endfunction
	function automatic logic [1:0] seen_pad(int i);
		return {pad[i].oe_n, pad[i].oe_n ? pad[i].weak_pu : pad[i].out};
	endfunction
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 20000) begin
			miscompares++;
			stop_test();
		end
	end
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge clk_sys);
		rst <= 0;
		@(posedge clk_sys);
		for (int i = 0; i < NUM_PINS; i++) check("pad_rst", seen_pad(i), 2'b10);
		for (int p = 0; p < 4; p++) begin
			rd(p * 16 + 4);
			check("cfg_a_rst", v, PORT_MASK[p]);
			rd(p * 16 + 8);
			check("cfg_b_rst", v, 0);
		end
		rd(8'h40);
		check("dis_rst", v, 0);
		// round 0 is all open-drain low, so the serial pins really drive
		for (int r = 0; r < 12; r++) begin
			for (int p = 0; p < 4; p++) begin
				ca[p] = r == 0 ? 8'hFF : 8'($random(seed));
				cb[p] = r == 0 ? 8'hFF : 8'($random(seed));
				la[p] = r == 0 ? 8'h00 : 8'($random(seed));
				wr(p * 16 + 4, ca[p]);
				wr(p * 16 + 8, cb[p]);
				wr(p * 16, la[p]);
			end
			repeat (2) @(posedge clk_sys);
			for (int i = 0; i < NUM_PINS; i++)
				check("pad", seen_pad(i), exp_pad(i, la[i/8][i%8],
					drive_mode_t'({ca[i/8][i%8], cb[i/8][i%8]})));
			rd(8'h34);
			check("cfg_a_rb", v, ca[3] & PORT_MASK[3]);
		end
		// strobe low on byte 0: the write is answered but ignored
		wstrb <= 4'hE;
		wr(8'h00, ~la[0]);
		wstrb <= 4'hF;
		check("strb_resp", resp, RESP_OKAY);
		rd(8'h00);
		check("strb_off", v, la[0]);
		for (int p = 0; p < 4; p++) begin
			wr(p * 16 + 4, 8'hFF);
			wr(p * 16 + 8, 8'h00);
		end
		drv_en <= '1;
		for (int k = 0; k < 5; k++) begin
			if (k == 2) wr(8'h40, 8'hFF);
			m = k >= 2 ? DIG_DIS_MASK : 8'h00;
			drv_val <= NUM_PINS'($random(seed));
			if (k == 4) begin
				@(posedge clk_sys);
				drv_val <= ~drv_val;
				@(posedge clk_sys);
				drv_val <= ~drv_val;
			end
			repeat (8) @(posedge clk_sys);
			for (int p = 0; p < 4; p++) begin
				rd(p * 16 + 12);
				check("pins", v, 8'(drv_val >> (p * 8)) & PORT_MASK[p] & (p == 0 ? ~m : 8'hFF));
			end
		end
		rd(8'h40);
		check("dis_rb", v, DIG_DIS_MASK);
		// mid-run reset must clear the disable bits and float every pad
		rst <= 1;
		repeat (2) @(posedge clk_sys);
		rst <= 0;
		@(posedge clk_sys);
		for (int i = 0; i < NUM_PINS; i++) check("pad_rst2", seen_pad(i), 2'b10);
		rd(8'h40);
		check("dis_rst2", v, 0);
		wr(8'h44, 8'h40);
		drv_val[PIN_RESET] <= 0;
		repeat (8) @(posedge clk_sys);
		check("rst_req_on", rst_req, 1);
		drv_val[PIN_RESET] <= 1;
		repeat (8) @(posedge clk_sys);
		check("rst_req_off", rst_req, 0);
		// a one-cycle low pulse must never reach the reset request
		drv_val[PIN_RESET] <= 0;
		@(posedge clk_sys);
		drv_val[PIN_RESET] <= 1;
		repeat (8) begin
			@(posedge clk_sys);
			check("glitch_rst", rst_req, 0);
		end
		wr(8'h0C, 8'h00);
		check("ro_resp", resp, RESP_OKAY);
		wr(8'h80, 8'h55);
		check("unmap_wr", resp, RESP_DECERR);
		rd(8'h80);
		check("unmap_rd", v, 32'h0);
		check("unmap_rresp", resp, RESP_DECERR);
		stop_test();
	end
endmodule
bind configurable_io_port_set io_port_asserts chk (.clk_sys(clk_sys), .rst(rst),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
	.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
	.s_axi_rready(s_axi_rready), .pad(pad));
